// >>> rtpmc_pkg.sv
`default_nettype none
package rtpmc_pkg;
   // Link address and data widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   // Device register indices
   localparam logic [3:0] REG_REFCLK  = 4'h0; // Bandgap off, PLL enable
   localparam logic [3:0] REG_CHA     = 4'h3; // Channel A standby / power-down
   localparam logic [3:0] REG_CHB     = 4'h4; // Channel B standby / power-down
   localparam logic [3:0] REG_RXJOINT = 4'h5; // Joint receive power-down
   localparam logic [3:0] REG_DCS     = 4'h6; // Duty cycle stabilizer enables
   localparam logic [3:0] REG_TXCTL   = 4'h7; // Interpolation, sleep, power-down, mode
   localparam logic [3:0] REG_RXRATE  = 4'h8; // Receive sample rate, MSPS
   localparam logic [3:0] REG_TXRATE  = 4'h9; // Transmit input rate per channel, MSPS
   localparam logic [3:0] REG_STATUS  = 4'hA; // Device status, read only
   // Host-local register indices
   localparam logic [3:0] HREG_PINS   = 4'hC; // Pin levels driven by the host
   localparam logic [3:0] HREG_STAT   = 4'hD; // Host status
   // Field positions
   localparam int B_BGOFF = 0;
   localparam int B_PLL   = 1;
   localparam int B_STBY  = 0;
   localparam int B_FPD   = 1;
   localparam int B_JPD   = 0;
   localparam int B_DCSA  = 0;
   localparam int B_DCSB  = 1;
   localparam int F_INT_LO = 0;
   localparam int F_INT_HI = 1;
   localparam int B_SLEEP = 2;
   localparam int B_TXFPD = 3;
   localparam int F_MOD_LO = 4;
   localparam int F_MOD_HI = 5;
   localparam int B_PIN_BIAS = 0;
   localparam int B_PIN_TXSD = 1;
   // Reset values
   localparam logic [7:0] RST_REG  = 8'h00;
   localparam logic [7:0] RST_RATE = 8'h00;
   // Interpolation and interface mode codes
   typedef enum logic [1:0] {RTPMC_INT_1X, RTPMC_INT_2X, RTPMC_INT_4X,
                             RTPMC_INT_RSV} rtpmc_interp_t;
   typedef enum logic [1:0] {RTPMC_FULL_DUPLEX, RTPMC_HALF_INTERLEAVED, RTPMC_HALF_WIDE,
                             RTPMC_MODE_RSV} rtpmc_mode_t;
   // Rate limits, MSPS
   localparam logic [7:0] LIM_NARROW  = 8'h50; // 80 at 1x and 2x
   localparam logic [7:0] LIM_WIDE_1X = 8'hA0; // 160 at 1x, wide half duplex
   localparam logic [7:0] LIM_4X      = 8'h32; // 50 at 4x
   localparam int        DAC_MAX_MSPS = 200;  // Converter peak rate
   localparam logic [7:0] DCS_MIN_MSPS = 8'h28; // 40 MSPS stabilizer floor
   // Timing
   localparam int CLK_PERIOD_NS   = 25;
   localparam int DCS_RELOCK_NS   = 3000;
   localparam int TX_RECOVER_NS   = 10000;
   localparam int RX_WAKE_NS      = 5000000;
   localparam int DCS_RELOCK_CYC  = (DCS_RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_RECOVER_CYC  = (TX_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RX_WAKE_CYC_DEF = (RX_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_FLUSH_CYC    = 32;
   localparam int RX_CNT_W = 18;
   localparam int TX_CNT_W = 9;
   // Transmit rate legal for interpolation and interface mode
   function automatic logic rtpmc_rate_ok(input logic [1:0] interp, input logic [1:0] mode,
                                          input logic [7:0] rate);
      logic [7:0] lim;
      lim = LIM_NARROW;
      if (interp == RTPMC_INT_4X) begin
         lim = LIM_4X;
      end else if (interp == RTPMC_INT_1X && mode == RTPMC_HALF_WIDE) begin
         lim = LIM_WIDE_1X;
      end
      return (interp != RTPMC_INT_RSV) && (rate <= lim);
   endfunction
endpackage
`default_nettype wire

// >>> rtpmc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtpmc_link_if;
   logic       cfg_wr;                   // Write strobe
   logic       cfg_rd;                   // Read strobe
   logic [3:0] cfg_addr;                 // Register index
   logic [7:0] cfg_wdata;                // Write data
   logic [7:0] cfg_rdata;                // Read data, cycle after strobe
   logic       receive_bias_halving_pin; // Halve receive bias
   logic       transmit_shutdown_pin;    // Transmit power-down
   logic       rx_ready;                 // Receive path settled
   logic       tx_ready;                 // Transmit path settled
   logic       tx_rate_fault;            // Rate over limit
   modport dev (input cfg_wr, cfg_rd, cfg_addr, cfg_wdata, receive_bias_halving_pin,
                transmit_shutdown_pin, output cfg_rdata, rx_ready, tx_ready, tx_rate_fault);
   modport host (output cfg_wr, cfg_rd, cfg_addr, cfg_wdata, receive_bias_halving_pin,
                 transmit_shutdown_pin, input cfg_rdata, rx_ready, tx_ready, tx_rate_fault);
endinterface
`default_nettype wire

// >>> rtpmc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module rtpmc_dev
   import rtpmc_pkg::*;
#(
   parameter int RX_WAKE_CYC = RX_WAKE_CYC_DEF // Receive wake-up wait
) (
   input  wire logic  clk,
   input  wire logic  rst,
   rtpmc_link_if.dev  link,
   output logic       rx_bandgap_en,
   output logic       rx_ref_en,
   output logic [1:0] adc_standby,
   output logic [1:0] adc_powerdown,
   output logic [1:0] dcs_en,
   output logic       rx_bias_half,
   output logic       interp_stage1_en,
   output logic       interp_stage2_en,
   output logic       tx_clk_en,
   output logic       tx_analog_en,
   output logic       tx_bias_en,
   output logic       dac_current_en,
   output logic       pll_clk_select
);
   logic [7:0] refclk_q;             // Bandgap and PLL control
   logic [7:0] cha_q;                // Channel A control
   logic [7:0] chb_q;                // Channel B control
   logic [7:0] rxjoint_q;            // Joint power-down
   logic [7:0] dcs_q;                // Stabilizer enables
   logic [7:0] txctl_q;              // Transmit control
   logic [7:0] rxrate_q;             // Receive rate
   logic [7:0] txrate_q;             // Transmit rate
   logic [7:0] rdata_q;              // Read data
   logic [7:0] status_d;             // Status word
   logic [RX_CNT_W-1:0] rx_cnt_q;    // Receive settling timer
   logic [TX_CNT_W-1:0] tx_cnt_q;    // Transmit settling timer
   logic [1:0] fpd_q;                // Last channel power-down
   logic       shut_q;               // Last shutdown pin
   logic       txfpd_q;              // Last transmit power-down
   logic [1:0] fpd;                  // Channel full power-down
   logic       tx_fpd;               // Transmit full power-down
   logic       wr_rate;              // Receive rate or stabilizer register written
   logic [1:0] interp;               // Interpolation code
   logic       rx_wake;              // A channel just left full power-down
   logic       tx_pin_wake;          // Shutdown pin just released
   logic       tx_flush_wake;        // Transmit full power-down just left

   // Effective channel power-down, joint bit forces both
   assign fpd[0] = cha_q[B_FPD] | rxjoint_q[B_JPD];
   assign fpd[1] = chb_q[B_FPD] | rxjoint_q[B_JPD];
   assign tx_fpd = txctl_q[B_TXFPD];
   assign interp = txctl_q[F_INT_HI:F_INT_LO];

   // Register writes; accepted in every power mode
   always_ff @(posedge clk) begin
      if (rst) begin
         refclk_q  <= RST_REG;
         cha_q     <= RST_REG;
         chb_q     <= RST_REG;
         rxjoint_q <= RST_REG;
         dcs_q     <= RST_REG;
         txctl_q   <= RST_REG;
         rxrate_q  <= RST_RATE;
         txrate_q  <= RST_RATE;
      end else if (link.cfg_wr) begin
         unique case (link.cfg_addr)
            REG_REFCLK:  refclk_q  <= link.cfg_wdata;
            REG_CHA:     cha_q     <= link.cfg_wdata;
            REG_CHB:     chb_q     <= link.cfg_wdata;
            REG_RXJOINT: rxjoint_q <= link.cfg_wdata;
            REG_DCS:     dcs_q     <= link.cfg_wdata;
            REG_TXCTL:   txctl_q   <= link.cfg_wdata;
            REG_RXRATE:  rxrate_q  <= link.cfg_wdata;
            REG_TXRATE:  txrate_q  <= link.cfg_wdata;
            default:     ; // Read-only or unmapped
         endcase
      end
   end

   // Status word
   always_comb begin
      status_d    = 8'h00;
      status_d[0] = link.rx_ready;
      status_d[1] = link.tx_ready;
      status_d[2] = link.tx_rate_fault;
      status_d[3] = rx_ref_en;
   end

   // Read data, one cycle after the strobe; unmapped reads zero
   // Held until the next read, so a late sample still sees it
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (link.cfg_rd) begin
         unique case (link.cfg_addr)
            REG_REFCLK:  rdata_q <= refclk_q;
            REG_CHA:     rdata_q <= cha_q;
            REG_CHB:     rdata_q <= chb_q;
            REG_RXJOINT: rdata_q <= rxjoint_q;
            REG_DCS:     rdata_q <= dcs_q;
            REG_TXCTL:   rdata_q <= txctl_q;
            REG_RXRATE:  rdata_q <= rxrate_q;
            REG_TXRATE:  rdata_q <= txrate_q;
            REG_STATUS:  rdata_q <= status_d;
            default:     rdata_q <= 8'h00;
         endcase
      end
   end
   assign link.cfg_rdata = rdata_q;

   // Receive power and reference controls
   assign rx_bandgap_en    = ~refclk_q[B_BGOFF] & rx_ref_en;
   assign rx_ref_en        = ~(fpd[0] & fpd[1]);
   assign adc_standby[0]   = cha_q[B_STBY];
   assign adc_standby[1]   = chb_q[B_STBY];
   assign adc_powerdown    = fpd;
   assign dcs_en[0]        = dcs_q[B_DCSA] & ~fpd[0];
   assign dcs_en[1]        = dcs_q[B_DCSB] & ~fpd[1];
   assign rx_bias_half     = link.receive_bias_halving_pin;

   // Transmit path: stage one for 2x and 4x, stage two only for 4x
   assign interp_stage1_en = tx_clk_en
                           & (interp == RTPMC_INT_2X | interp == RTPMC_INT_4X);
   assign interp_stage2_en = tx_clk_en & (interp == RTPMC_INT_4X);
   // Shutdown pin stops clocks and some analog, biases kept
   assign tx_clk_en      = ~link.transmit_shutdown_pin & ~tx_fpd;
   assign tx_analog_en   = ~link.transmit_shutdown_pin & ~tx_fpd;
   assign tx_bias_en     = ~tx_fpd;
   // Sleep only removes converter output current
   assign dac_current_en = tx_analog_en & ~txctl_q[B_SLEEP];
   // Multiplied clock feeds interpolators and converters
   assign pll_clk_select = refclk_q[B_PLL];
   // Rate over the limit for the chosen interpolation
   assign link.tx_rate_fault = ~rtpmc_rate_ok(interp, txctl_q[F_MOD_HI:F_MOD_LO],
                                              txrate_q);

   // Edge history for wake-up detection
   always_ff @(posedge clk) begin
      if (rst) begin
         fpd_q   <= 2'h0;
         shut_q  <= 1'b0;
         txfpd_q <= 1'b0;
      end else begin
         fpd_q   <= fpd;
         shut_q  <= link.transmit_shutdown_pin;
         txfpd_q <= tx_fpd;
      end
   end

   // Wake events, one cycle after the control is released;
   // the timers load on this edge, so ready is held low here too
   assign rx_wake       = |(fpd_q & ~fpd);
   assign tx_pin_wake   = shut_q & ~link.transmit_shutdown_pin;
   assign tx_flush_wake = txfpd_q & ~tx_fpd;

   // Stabilizer relock on rate change or stabilizer enable
   assign wr_rate = link.cfg_wr & (link.cfg_addr == REG_RXRATE | link.cfg_addr == REG_DCS);

   // Receive settling timer: reference recharge or loop relock
   // A relock never shortens a longer reference wake-up already running
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_cnt_q <= '0;
      end else if (rx_wake) begin // Reference capacitors recharging
         rx_cnt_q <= RX_CNT_W'(RX_WAKE_CYC);
      end else if (wr_rate && (dcs_q[B_DCSA] | dcs_q[B_DCSB] | (|link.cfg_wdata))
                   && rx_cnt_q < RX_CNT_W'(DCS_RELOCK_CYC)) begin
         rx_cnt_q <= RX_CNT_W'(DCS_RELOCK_CYC);
      end else if (rx_cnt_q != '0) begin
         rx_cnt_q <= rx_cnt_q - 1'b1;
      end
   end
   // No ready in the wake cycle itself, before the timer has loaded
   assign link.rx_ready = (rx_cnt_q == '0) & rx_ref_en & ~rx_wake;

   // Transmit settling timer: pin recovery or filter flush
   // A flush never shortens a pin recovery already running
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_cnt_q <= '0;
      end else if (tx_pin_wake) begin // Biases kept, quick restart
         tx_cnt_q <= TX_CNT_W'(TX_RECOVER_CYC);
      end else if (tx_flush_wake && tx_cnt_q < TX_CNT_W'(TX_FLUSH_CYC)) begin // Filter flush
         tx_cnt_q <= TX_CNT_W'(TX_FLUSH_CYC);
      end else if (tx_cnt_q != '0) begin
         tx_cnt_q <= tx_cnt_q - 1'b1;
      end
   end
   // No ready in the wake cycle itself, before the timer has loaded
   assign link.tx_ready = (tx_cnt_q == '0) & tx_clk_en
                        & ~tx_pin_wake & ~tx_flush_wake;
endmodule
`default_nettype wire

// >>> rtpmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module rtpmc_host
   import rtpmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [3:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_wr,
   input  wire logic       sw_rd,
   output logic [7:0]      sw_rdata,
   output logic            rx_data_usable,
   output logic            tx_data_usable,
   rtpmc_link_if.host      link
);
   logic [7:0] pins_q;     // Pin levels
   logic [7:0] rxrate_q;   // Shadow receive rate
   logic [7:0] txrate_q;   // Shadow transmit rate
   logic [7:0] txctl_q;    // Shadow transmit control
   logic       refused_q;  // Sticky: write refused
   logic       local_q;    // Last read was host-local
   logic [7:0] local_rd_q; // Host-local read data
   logic       dev_wr;     // Write aimed at device
   logic       tx_bad;     // Transmit setting over limit
   logic [7:0] wdata;      // Data forwarded

   assign dev_wr = sw_wr & (sw_addr <= REG_STATUS);
   // Reject a transmit control or rate write that breaks the limits
   assign tx_bad = (sw_addr == REG_TXCTL
                    && !rtpmc_rate_ok(sw_wdata[F_INT_HI:F_INT_LO], sw_wdata[F_MOD_HI:F_MOD_LO],
                                      txrate_q))
                 | (sw_addr == REG_TXRATE
                    && !rtpmc_rate_ok(txctl_q[F_INT_HI:F_INT_LO], txctl_q[F_MOD_HI:F_MOD_LO],
                                      sw_wdata));

   // Stabilizer write data cleared while receive rate below floor
   always_comb begin
      wdata = sw_wdata;
      if (sw_addr == REG_DCS && rxrate_q < DCS_MIN_MSPS) begin
         wdata = 8'h00;
      end
   end

   // Link strobes for device addresses only; a write that breaks the limits is not forwarded
   assign link.cfg_wr    = dev_wr & ~tx_bad;
   assign link.cfg_rd    = sw_rd & (sw_addr <= REG_STATUS);
   assign link.cfg_addr  = sw_addr;
   assign link.cfg_wdata = wdata;
   assign link.receive_bias_halving_pin = pins_q[B_PIN_BIAS];
   assign link.transmit_shutdown_pin    = pins_q[B_PIN_TXSD];

   // Host-local and shadow registers
   always_ff @(posedge clk) begin
      if (rst) begin
         pins_q   <= RST_REG;
         rxrate_q <= RST_RATE;
         txrate_q <= RST_RATE;
         txctl_q  <= RST_REG;
      end else if (sw_wr) begin
         if (sw_addr == HREG_PINS) begin
            pins_q <= sw_wdata;
         end
         if (sw_addr == REG_RXRATE) begin
            rxrate_q <= sw_wdata;
         end
         if (link.cfg_wr && sw_addr == REG_TXRATE) begin
            txrate_q <= sw_wdata;
         end
         if (link.cfg_wr && sw_addr == REG_TXCTL) begin
            txctl_q <= sw_wdata;
         end
      end
   end

   // Sticky refusal flag; a new refusal wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         refused_q <= 1'b0;
      end else if (dev_wr & tx_bad) begin
         refused_q <= 1'b1;
      end else if (sw_wr && sw_addr == HREG_STAT && sw_wdata[3]) begin
         refused_q <= 1'b0;
      end
   end

   // Local read path, device reads come back on the link
   always_ff @(posedge clk) begin
      if (rst) begin
         local_q    <= 1'b0;
         local_rd_q <= 8'h00;
      end else if (sw_rd) begin
         local_q <= (sw_addr > REG_STATUS);
         unique case (sw_addr)
            HREG_PINS: local_rd_q <= pins_q;
            HREG_STAT: local_rd_q <= {4'h0, refused_q, link.tx_rate_fault,
                                      link.tx_ready, link.rx_ready};
            default:   local_rd_q <= 8'h00;
         endcase
      end
   end
   assign sw_rdata = local_q ? local_rd_q : link.cfg_rdata;

   // Data trusted only once the device has settled
   assign rx_data_usable = link.rx_ready;
   assign tx_data_usable = link.tx_ready & ~link.tx_rate_fault;
endmodule
`default_nettype wire

// >>> rtpmc_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rtpmc_link_checker
   import rtpmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       cfg_wr,
   input  wire logic       cfg_rd,
   input  wire logic [3:0] cfg_addr,
   input  wire logic [7:0] cfg_wdata,
   input  wire logic [7:0] cfg_rdata,
   input  wire logic       receive_bias_halving_pin,
   input  wire logic       transmit_shutdown_pin,
   input  wire logic       rx_ready,
   input  wire logic       tx_ready,
   input  wire logic       tx_rate_fault
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [7:0] rate_q; // Receive rate last forwarded
   logic       pin_q;  // Shutdown pin one cycle back
   logic [9:0] rec_q;  // Cycles since shutdown release
   // Shadow of the forwarded receive rate
   always_ff @(posedge clk) begin
      if (rst) rate_q <= 8'h00;
      else if (cfg_wr && cfg_addr == REG_RXRATE) rate_q <= cfg_wdata;
   end
   // Count from the release of the shutdown pin, saturating
   always_ff @(posedge clk) begin
      pin_q <= !rst && transmit_shutdown_pin;
      if (rst || transmit_shutdown_pin) rec_q <= 10'h000;
      else if ((pin_q || rec_q != 10'h000) && rec_q != 10'h3FF) rec_q <= rec_q + 10'h001;
   end
   property p_excl; !(cfg_wr && cfg_rd); endproperty
   a_excl: assert property (p_excl) else $error("both strobes high");
   property p_unmapped; cfg_rd && cfg_addr == 4'h2 |=> cfg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_status;
      cfg_rd && cfg_addr == REG_STATUS |=>
         cfg_rdata[2:0] == {$past(tx_rate_fault), $past(tx_ready), $past(rx_ready)};
   endproperty
   a_status: assert property (p_status) else $error("status read mismatch");
   property p_dcs_floor;
      cfg_wr && cfg_addr == REG_DCS && rate_q < DCS_MIN_MSPS |-> cfg_wdata == 8'h00;
   endproperty
   a_dcs_floor: assert property (p_dcs_floor) else $error("stabilizer on at low rate");
   property p_rx_relock;
      cfg_wr && cfg_addr == REG_DCS && cfg_wdata != 8'h00 |=> (!rx_ready)[*8];
   endproperty
   a_rx_relock: assert property (p_rx_relock) else $error("receive ready in relock");
   property p_tx_hold;
      transmit_shutdown_pin && $past(transmit_shutdown_pin) && $past(transmit_shutdown_pin, 2)
         |-> !tx_ready;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmit ready in shutdown");
   property p_tx_recover;
      (pin_q || rec_q != 10'h000) && rec_q < 10'h186 |-> !tx_ready;
   endproperty
   a_tx_recover: assert property (p_tx_recover) else $error("transmit ready too early");
   property p_tx_resume; rec_q == 10'h19A |-> tx_ready; endproperty
   a_tx_resume: assert property (p_tx_resume) else $error("transmit ready too late");
   property p_no_fault; !tx_rate_fault; endproperty
   a_no_fault: assert property (p_no_fault) else $error("illegal rate reached device");
   property p_rst_ready; $fell(rst) |-> rx_ready && tx_ready; endproperty
   a_rst_ready: assert property (p_rst_ready) else $error("not ready after reset");
endmodule
`default_nettype wire

// >>> test_rx_tx_power_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_rx_tx_power_mode_control;
   import rtpmc_pkg::*;
   localparam int RXW = 50;      // Short receive wake-up
   logic        clk      = 1'b0;  // 40 MHz clock
   logic        rst      = 1'b1;  // Synchronous reset
   logic [3:0]  sw_addr  = 4'h0;  // Software address
   logic [7:0]  sw_wdata = 8'h00; // Software write data
   logic        sw_wr    = 1'b0;  // Write strobe
   logic        sw_rd    = 1'b0;  // Read strobe
   logic [7:0]  sw_rdata;         // Read data
   logic        rx_data_usable;   // Receive settled
   logic        tx_data_usable;   // Transmit settled
   wire logic [15:0] dv;          // Device power controls, packed
   int          error_cnt = 0;    // Mismatches
   int          compares  = 0;    // Comparisons made
   rtpmc_link_if link ();
   rtpmc_host i_rtpmc_host (.clk(clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .rx_data_usable(rx_data_usable),
      .tx_data_usable(tx_data_usable), .link(link));
   rtpmc_dev #(.RX_WAKE_CYC(RXW)) i_rtpmc_dev (.clk(clk), .rst(rst), .link(link),
      .rx_bandgap_en(dv[15]), .rx_ref_en(dv[14]), .adc_standby(dv[13:12]),
      .adc_powerdown(dv[11:10]), .dcs_en(dv[9:8]), .rx_bias_half(dv[7]),
      .interp_stage1_en(dv[6]), .interp_stage2_en(dv[5]), .tx_clk_en(dv[4]),
      .tx_analog_en(dv[3]), .tx_bias_en(dv[2]), .dac_current_en(dv[1]), .pll_clk_select(dv[0]));
   rtpmc_link_checker i_rtpmc_link_checker (.clk(clk), .rst(rst), .cfg_wr(link.cfg_wr),
      .cfg_rd(link.cfg_rd), .cfg_addr(link.cfg_addr), .cfg_wdata(link.cfg_wdata),
      .cfg_rdata(link.cfg_rdata), .receive_bias_halving_pin(link.receive_bias_halving_pin),
      .transmit_shutdown_pin(link.transmit_shutdown_pin), .rx_ready(link.rx_ready),
      .tx_ready(link.tx_ready), .tx_rate_fault(link.tx_rate_fault));
   // Free-running clock
   always #12.5 clk = ~clk;
   // Log one comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write, then one idle edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
      @(posedge clk);
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      @(posedge clk);
      d = sw_rdata;
   endtask
   // Count cycles until a ready flag rises, then check the span
   task automatic wait_rdy(input logic tx, input int lo, input int hi);
      int n;
      n = 0;
      while ((tx ? tx_data_usable : rx_data_usable) !== 1'b1 && n < hi + 50) begin
         @(posedge clk);
         n++;
      end
      chk(16'(n >= lo && n <= hi), 16'h0001);
   endtask
   // Receive standby, power-down and wake-up
   task automatic t_rx();
      logic [7:0] d;
      wr(REG_CHA, 8'h01);
      chk(dv, 16'hD01E);
      wr(REG_CHB, 8'h01);
      chk(dv, 16'hF01E);
      wr(REG_CHB, 8'h02);
      chk(dv, 16'hD81E);
      wr(REG_CHA, 8'h02);
      chk(dv, 16'h0C1E);
      rd(REG_STATUS, d);
      chk(16'(d[3]), 16'h0000);
      wr(REG_RXJOINT, 8'h01);
      wr(REG_CHA, 8'h00);
      wr(REG_CHB, 8'h00);
      chk(dv, 16'h0C1E);
      wr(REG_RXJOINT, 8'h00);
      wait_rdy(1'b0, RXW - 4, RXW + 2);
      chk(dv, 16'hC01E);
   endtask
   // Reference, interpolation, sleep, power-down and shutdown pin
   task automatic t_tx();
      logic [7:0] d;
      wr(REG_REFCLK, 8'h03);
      chk(dv, 16'h401F);
      wr(REG_REFCLK, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(REG_TXCTL, 8'(i));
         chk(16'(dv[6:5]), {14'h0000, i != 0, i == 2});
      end
      wr(REG_TXCTL, 8'h04);
      chk(16'(dv[4:1]), 16'h000E);
      wr(REG_TXCTL, 8'h0A);
      chk({dv[6:1], 9'h000, tx_data_usable}, 16'h0000);
      wr(REG_TXCTL, 8'h02);
      wait_rdy(1'b1, 28, 34);
      chk(16'(dv[6:1]), 16'h003F);
      wr(HREG_PINS, 8'h02);
      chk({dv[7:1], 8'h00, tx_data_usable}, {7'h02, 9'h000});
      rd(REG_STATUS, d);
      chk(16'(d[1:0]), 16'h0001);
      wr(HREG_PINS, 8'h01);
      chk(16'(dv[7]), 16'h0001);
      wait_rdy(1'b1, 393, 408);
      wr(HREG_PINS, 8'h00);
   endtask
   // Transmit rate limits against interpolation and interface mode
   task automatic t_rates();
      logic [3:0] a [11] = '{REG_TXCTL, REG_TXRATE, REG_TXRATE, REG_TXCTL, REG_TXRATE,
         REG_TXRATE, REG_TXCTL, REG_TXCTL, REG_TXCTL, REG_TXRATE, REG_TXCTL};
      logic [7:0] v [11] = '{8'h02, 8'h33, 8'h32, 8'h20, 8'hA0, 8'hA1, 8'h01, 8'h03, 8'h00,
         8'h50, 8'h01};
      logic       r [11] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      logic [7:0] d;
      for (int i = 0; i < 11; i++) begin
         wr(a[i], v[i]);
         rd(HREG_STAT, d);
         chk({14'h0000, d[3], tx_data_usable}, {14'h0000, r[i], 1'b1});
         wr(HREG_STAT, 8'h08);
      end
   endtask
   // Stabilizer enables, low-rate guard and relock wait
   task automatic t_dcs();
      logic [7:0] d;
      wr(REG_RXRATE, 8'h27);
      wait_rdy(1'b0, 0, 260);
      wr(REG_DCS, 8'h03);
      chk(16'(dv[9:8]), 16'h0000);
      wait_rdy(1'b0, 0, 260);
      wr(REG_RXRATE, 8'h50);
      wait_rdy(1'b0, 0, 260);
      wr(REG_DCS, 8'h01);
      chk(16'(dv[9:8]), 16'h0001);
      wait_rdy(1'b0, 115, 260);
      wr(REG_RXRATE, 8'h48);
      wait_rdy(1'b0, 115, 260);
      wr(REG_DCS, 8'h03);
      chk(16'(dv[9:8]), 16'h0003);
      rd(4'h2, d);
      chk(16'(d), 16'h0000);
   endtask
   // Print counts and verdict, then stop
   task automatic conclude();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(dv, 16'hC01E);
      chk({14'h0000, rx_data_usable, tx_data_usable}, 16'h0003);
      t_rx();
      t_tx();
      t_rates();
      t_dcs();
      conclude();
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
